// ### core/fiaps_axil_slave.sv
// AXI4-Lite slave front end producing a register write strobe and a register read address
`timescale 1ns/10ps
module fiaps_axil_slave
    import fiaps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic regWrStb,
    output logic [7:0] regWrAddr,
    output logic [7:0] regWrData,
    output logic [7:0] regRdAddr,
    input wire logic [7:0] regRdData
);

    logic awHeld_r, wHeld_r;
    logic [7:0] awAddr_r;
    logic [7:0] wData_r;
    logic wLane_r;
    logic wrMapped;
    logic rdMapped;

    assign awready = !awHeld_r && !bvalid;
    assign wready = !wHeld_r && !bvalid;
    assign arready = !rvalid;
    assign wrMapped = (awAddr_r[1:0] == 2'h0) && (awAddr_r <= OFF_LAST);
    assign rdMapped = (araddr[1:0] == 2'h0) && (araddr <= OFF_LAST);
    // Only byte lane 0 carries register bits
    assign regWrStb = awHeld_r && wHeld_r && wLane_r && wrMapped;
    assign regWrAddr = awAddr_r;
    assign regWrData = wData_r;
    assign regRdAddr = araddr;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 8'h00;
            wLane_r <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata[7:0];
                wLane_r <= wstrb[0];
            end
            if (awHeld_r && wHeld_r) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rdMapped ? {24'h00_0000, regRdData} : 32'h0000_0000;
            rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule : fiaps_axil_slave

// ### core/fiaps_pkg.sv
// Package of offsets, field positions, reset values and timings for the sequencer
package fiaps_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFF_CTRL_MAIN = 8'h00;
    localparam logic [7:0] OFF_CTRL_TIMING = 8'h04;
    localparam logic [7:0] OFF_ADDR_LOW = 8'h08;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h0C;
    localparam logic [7:0] OFF_DATA_LOW = 8'h10;
    localparam logic [7:0] OFF_DATA_HIGH = 8'h14;
    localparam logic [7:0] OFF_KEY_A_LOW = 8'h18;
    localparam logic [7:0] OFF_KEY_B_LOW = 8'h1C;
    localparam logic [7:0] OFF_KEY_C_LOW = 8'h20;
    localparam logic [7:0] OFF_KEY_A_HIGH = 8'h24;
    localparam logic [7:0] OFF_KEY_B_HIGH = 8'h28;
    localparam logic [7:0] OFF_KEY_C_HIGH = 8'h2C;
    localparam logic [7:0] OFF_LAST = 8'h2C;

    // Field positions in flash_ctrl_main
    localparam int POS_OP_SELECT = 0;
    localparam int POS_UNLOCK_TRIGGER = 3;
    localparam int POS_PROGRAM_START = 4;
    localparam int POS_ERASE_WRITE_EN = 5;
    localparam int POS_BUSY = 6;
    // Field positions in flash_ctrl_timing
    localparam int POS_BUF_CLEAR = 0;
    localparam int POS_DUR_SELECT = 1;

    // Operation select codes
    localparam logic [2:0] OP_WRITE = 3'h0;
    localparam logic [2:0] OP_ERASE = 3'h1;
    localparam logic [2:0] OP_UNLOCK = 3'h6;

    // Unlock key, in the order it must be written
    localparam logic [7:0] KEY_0 = 8'h00;
    localparam logic [7:0] KEY_1 = 8'h0D;
    localparam logic [7:0] KEY_2 = 8'hC3;
    localparam logic [7:0] KEY_3 = 8'h04;
    localparam logic [7:0] KEY_4 = 8'h09;
    localparam logic [7:0] KEY_5 = 8'h40;
    localparam logic [2:0] KEY_COUNT = 3'h6;

    // Geometry
    localparam int ADDR_W = 13;
    localparam int WORD_W = 16;
    localparam int PAGE_WORDS = 32;
    localparam logic [4:0] PAGE_LAST = 5'h1F;
    localparam logic [WORD_W-1:0] ERASED_WORD = 16'h0000;
    localparam logic [WORD_W-1:0] BUF_RESET = 16'h0000;

    // Timing at 125 MHz
    localparam longint CLK_KHZ = 125000;
    localparam longint ERASE_T0_NS = 3200000;
    localparam longint WRITE_T0_NS = 2200000;
    localparam longint ERASE_T1_NS = 3700000;
    localparam longint WRITE_T1_NS = 3000000;
    localparam int ERASE_T0_CYC = int'(ERASE_T0_NS * CLK_KHZ / 1000000);
    localparam int WRITE_T0_CYC = int'(WRITE_T0_NS * CLK_KHZ / 1000000);
    localparam int ERASE_T1_CYC = int'(ERASE_T1_NS * CLK_KHZ / 1000000);
    localparam int WRITE_T1_CYC = int'(WRITE_T1_NS * CLK_KHZ / 1000000);
    localparam int UNLOCK_WINDOW_CYC = 1024;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fiaps_pkg

// ### core/fiaps_sequencer.sv
// Flash in-application erase/write sequencer with unlock and page buffer
// Contract
// - Successful unlock sets enabled flag; only then erase or write run.
// - Page erase and page write need the enabled flag high.
// - Each high data write tags address and increments; holds at 11111b.
// - Erase touches only addresses tagged by high data writes.
// - Erased words are written as 0000h for blank check.
// - Buffer clear empties the buffer before reload and rewrite.
// - Software clearing enabled flag disables erase and write at once; a main write that clears it with the start bit set still starts.
// - Op select 110 is unlock mode; trigger bit starts key check.
// - Trigger bit starts timeout timer; keys must arrive before expiry.
// - Key 00,0D,C3,04,09,40 to low regs a-c then high regs a-c.
// - Timer expiry clears trigger bit by hardware regardless of keys.
// - Wrong key leaves erase/write disabled; correct key enables it.
// - Buffer holds 32 words, one page chosen by address bits 12..5.
// - Each low-then-high data write advances buffer address by one.
// - Buffer address stops at last word of page.
// - Op select 001 is erase; start bit erases tagged page.
// - Op select 000 is write; start bit programs buffered words.
// - Start in write mode transfers buffer; start bit falls when done.
// - Processor halted while erase or write is active.
// - Time until start bit falls depends on duration select bit.
// - Select 0: erase 3.2ms, write 2.2ms; select 1: 3.7ms, 3.0ms.
// - High data write loads high and low bytes; low write only stores.
// - Start bit set by software, cleared by hardware on completion.
// - Buffer clear bit set by software, cleared by hardware when done.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module fiaps_sequencer
    import fiaps_pkg::*;
#(
    parameter int ERASE_SEL0_CYC = ERASE_T0_CYC,
    parameter int WRITE_SEL0_CYC = WRITE_T0_CYC,
    parameter int ERASE_SEL1_CYC = ERASE_T1_CYC,
    parameter int WRITE_SEL1_CYC = WRITE_T1_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic cpuHalt,
    output logic flashWe,
    output logic [ADDR_W-1:0] flashAddr,
    output logic [WORD_W-1:0] flashData
);

    typedef enum logic [1:0] {ST_IDLE, ST_WALK, ST_WAIT} fiaps_state_t;

    logic regWrStb;
    logic [7:0] regWrAddr, regWrData, regRdAddr;
    logic [7:0] regRdData;
    logic [2:0] opSel_r;
    logic unlockTrig_r, programStart_r, enabled_r;
    logic bufClear_r, durSel_r;
    logic [ADDR_W-1:0] addr_r;
    logic [7:0] dataLow_r, dataHigh_r;
    logic [7:0] keyReg_r [6];
    logic [2:0] keyProgress_r;
    logic [10:0] unlockCnt_r;
    logic [PAGE_WORDS-1:0] tag_r;
    fiaps_state_t state_r;
    logic opErase_r;
    logic [4:0] walkIdx_r;
    logic [31:0] opCnt_r, opLimit_r;
    logic [WORD_W-1:0] bufRdData;
    logic bufRdValid;
    logic wrMain, wrTiming, wrHigh, startReq, opDone, unlockExpire;
    logic keyHit;
    logic [2:0] keySlot;
    logic keySlotOk;
    logic [7:0] keyExpect;

    ////////////////////////////////////////////////////////////////////////
    fiaps_axil_slave u_bus (
        .clk_sys(clk_sys),
        .rst(rst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .regWrStb(regWrStb),
        .regWrAddr(regWrAddr),
        .regWrData(regWrData),
        .regRdAddr(regRdAddr),
        .regRdData(regRdData)
    );

    fiaps_write_buffer u_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(bufClear_r),
        .load(wrHigh),
        .loadIdx(addr_r[4:0]),
        .loadData({regWrData, dataLow_r}),
        .readIdx(walkIdx_r),
        .readData(bufRdData),
        .readValid(bufRdValid)
    );

    ////////////////////////////////////////////////////////////////////////
    assign wrMain = regWrStb && regWrAddr == OFF_CTRL_MAIN;
    assign wrTiming = regWrStb && regWrAddr == OFF_CTRL_TIMING;
    assign wrHigh = regWrStb && regWrAddr == OFF_DATA_HIGH;
    // Start is honoured only when idle, enabled and in erase or write mode
    assign startReq = wrMain && regWrData[POS_PROGRAM_START] && enabled_r
        && state_r == ST_IDLE
        && (regWrData[2:0] == OP_ERASE || regWrData[2:0] == OP_WRITE);
    assign opDone = state_r == ST_WAIT && opCnt_r >= opLimit_r;
    assign unlockExpire = unlockTrig_r
        && unlockCnt_r == 11'(UNLOCK_WINDOW_CYC - 1);

    // Key slot order: low a, b, c then high a, b, c
    always_comb begin
        keySlotOk = 1'b1;
        keySlot = 3'h0;
        case (regWrAddr)
            OFF_KEY_A_LOW: keySlot = 3'h0;
            OFF_KEY_B_LOW: keySlot = 3'h1;
            OFF_KEY_C_LOW: keySlot = 3'h2;
            OFF_KEY_A_HIGH: keySlot = 3'h3;
            OFF_KEY_B_HIGH: keySlot = 3'h4;
            OFF_KEY_C_HIGH: keySlot = 3'h5;
            default: keySlotOk = 1'b0;
        endcase
    end

    always_comb begin
        case (keyProgress_r)
            3'h0: keyExpect = KEY_0;
            3'h1: keyExpect = KEY_1;
            3'h2: keyExpect = KEY_2;
            3'h3: keyExpect = KEY_3;
            3'h4: keyExpect = KEY_4;
            default: keyExpect = KEY_5;
        endcase
    end

    assign keyHit = regWrStb && keySlotOk && unlockTrig_r
        && keySlot == keyProgress_r && regWrData == keyExpect;

    ////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            opSel_r <= OP_WRITE;
            programStart_r <= 1'b0;
        end else begin
            if (wrMain && state_r == ST_IDLE) begin
                opSel_r <= regWrData[2:0];
            end
            if (startReq) begin
                programStart_r <= 1'b1;
            end else if (opDone) begin
                programStart_r <= 1'b0;
            end
        end
    end

    // Unlock trigger and its timeout
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unlockTrig_r <= 1'b0;
            unlockCnt_r <= 11'h000;
        end else if (wrMain && regWrData[POS_UNLOCK_TRIGGER]
                     && regWrData[2:0] == OP_UNLOCK) begin
            unlockTrig_r <= 1'b1;
            unlockCnt_r <= 11'h000;
        end else if (unlockExpire) begin
            unlockTrig_r <= 1'b0;
        end else if (unlockTrig_r) begin
            unlockCnt_r <= unlockCnt_r + 11'h001;
        end
    end

    // Key progress; any out-of-order or wrong value starts over
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            keyProgress_r <= 3'h0;
        end else if (!unlockTrig_r || keyProgress_r == KEY_COUNT) begin
            keyProgress_r <= 3'h0;
        end else if (keyHit) begin
            keyProgress_r <= keyProgress_r + 3'h1;
        end else if (regWrStb && keySlotOk) begin
            keyProgress_r <= 3'h0;
        end
    end

    // Enabled flag: hardware set wins over a software clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enabled_r <= 1'b0;
        end else if (unlockTrig_r && keyProgress_r == KEY_COUNT) begin
            enabled_r <= 1'b1;
        end else if (wrMain && !regWrData[POS_ERASE_WRITE_EN]) begin
            enabled_r <= 1'b0;
        end
    end

    // Timing register; buffer clear lasts one cycle, not while busy
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bufClear_r <= 1'b0;
            durSel_r <= 1'b0;
        end else begin
            if (wrTiming && state_r == ST_IDLE) begin
                durSel_r <= regWrData[POS_DUR_SELECT];
            end
            if (wrTiming && regWrData[POS_BUF_CLEAR] && state_r == ST_IDLE) begin
                bufClear_r <= 1'b1;
            end else begin
                bufClear_r <= 1'b0;
            end
        end
    end

    // Address, data and key registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_r <= 13'h0000;
            dataLow_r <= 8'h00;
            dataHigh_r <= 8'h00;
            for (int i = 0; i < 6; i++) begin
                keyReg_r[i] <= 8'h00;
            end
        end else if (regWrStb) begin
            if (regWrAddr == OFF_ADDR_LOW) begin
                addr_r[7:0] <= regWrData;
            end
            if (regWrAddr == OFF_ADDR_HIGH) begin
                addr_r[12:8] <= regWrData[4:0];
            end
            if (regWrAddr == OFF_DATA_LOW) begin
                dataLow_r <= regWrData;
            end
            if (wrHigh) begin
                dataHigh_r <= regWrData;
                if (addr_r[4:0] != PAGE_LAST) begin
                    addr_r <= addr_r + 13'h0001;
                end
            end
            if (keySlotOk) begin
                keyReg_r[keySlot] <= regWrData;
            end
        end
    end

    // Erase tags survive buffer clear; a finished erase drops them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tag_r <= '0;
        end else begin
            if (opDone && opErase_r) begin
                tag_r <= '0;
            end
            if (wrHigh) begin
                tag_r[addr_r[4:0]] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation engine: walk the page, then wait out the selected time
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            opErase_r <= 1'b0;
            walkIdx_r <= 5'h00;
            opCnt_r <= 32'h0000_0000;
            opLimit_r <= 32'h0000_0000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (startReq) begin
                        state_r <= ST_WALK;
                        opErase_r <= regWrData[2:0] == OP_ERASE;
                        walkIdx_r <= 5'h00;
                        opCnt_r <= 32'h0000_0001;
                        if (regWrData[2:0] == OP_ERASE) begin
                            opLimit_r <= durSel_r ? 32'(ERASE_SEL1_CYC)
                                : 32'(ERASE_SEL0_CYC);
                        end else begin
                            opLimit_r <= durSel_r ? 32'(WRITE_SEL1_CYC)
                                : 32'(WRITE_SEL0_CYC);
                        end
                    end
                end
                ST_WALK: begin
                    opCnt_r <= opCnt_r + 32'h0000_0001;
                    walkIdx_r <= walkIdx_r + 5'h01;
                    if (walkIdx_r == PAGE_LAST) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    opCnt_r <= opCnt_r + 32'h0000_0001;
                    if (opDone) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Flash port: registered word writes during the walk
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flashWe <= 1'b0;
            flashAddr <= 13'h0000;
            flashData <= 16'h0000;
        end else begin
            flashAddr <= {addr_r[12:5], walkIdx_r};
            if (state_r == ST_WALK && opErase_r) begin
                flashWe <= tag_r[walkIdx_r];
                flashData <= ERASED_WORD;
            end else if (state_r == ST_WALK) begin
                flashWe <= bufRdValid;
                flashData <= bufRdData;
            end else begin
                flashWe <= 1'b0;
                flashData <= 16'h0000;
            end
        end
    end

    // Whole-core halt; too coarse for debug but matches the stall
    assign cpuHalt = state_r != ST_IDLE;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        regRdData = 8'h00;
        case (regRdAddr)
            OFF_CTRL_MAIN: regRdData = {1'b0, cpuHalt, enabled_r,
                programStart_r, unlockTrig_r, opSel_r};
            OFF_CTRL_TIMING: regRdData = {6'h00, durSel_r, bufClear_r};
            OFF_ADDR_LOW: regRdData = addr_r[7:0];
            OFF_ADDR_HIGH: regRdData = {3'h0, addr_r[12:8]};
            OFF_DATA_LOW: regRdData = dataLow_r;
            OFF_DATA_HIGH: regRdData = dataHigh_r;
            OFF_KEY_A_LOW: regRdData = keyReg_r[0];
            OFF_KEY_B_LOW: regRdData = keyReg_r[1];
            OFF_KEY_C_LOW: regRdData = keyReg_r[2];
            OFF_KEY_A_HIGH: regRdData = keyReg_r[3];
            OFF_KEY_B_HIGH: regRdData = keyReg_r[4];
            OFF_KEY_C_HIGH: regRdData = keyReg_r[5];
            default: regRdData = 8'h00;
        endcase
    end

endmodule : fiaps_sequencer

// ### core/fiaps_write_buffer.sv
// One-page write buffer of 32 sixteen-bit words with valid bits
`timescale 1ns/10ps
module fiaps_write_buffer
    import fiaps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clear,
    input wire logic load,
    input wire logic [4:0] loadIdx,
    input wire logic [WORD_W-1:0] loadData,
    input wire logic [4:0] readIdx,
    output logic [WORD_W-1:0] readData,
    output logic readValid
);

    logic [WORD_W-1:0] word_r [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] valid_r;

    assign readData = word_r[readIdx];
    assign readValid = valid_r[readIdx];

    genvar gi;
    generate
        for (gi = 0; gi < PAGE_WORDS; gi++) begin : g_word
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    word_r[gi] <= BUF_RESET;
                    valid_r[gi] <= 1'b0;
                end else if (clear) begin
                    word_r[gi] <= BUF_RESET;
                    valid_r[gi] <= 1'b0;
                end else if (load && loadIdx == 5'(gi)) begin
                    word_r[gi] <= loadData;
                    valid_r[gi] <= 1'b1;
                end
            end
        end
    endgenerate

endmodule : fiaps_write_buffer

// ### dv/fiaps_sequencer_bench.sv
// Register-level bench for the erase/write sequencer
`timescale 1ns/10ps
module fiaps_sequencer_bench;
    import fiaps_pkg::*;
    localparam int E0 = 100;
    localparam int W1 = 90;
    logic clk_sys, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready;
    logic rvalid, cpuHalt, flashWe;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic [12:0] flashAddr, weA[$];
    logic [15:0] flashData, weD[$];
    int failures = 0, comparisons = 0, haltCnt;
    fiaps_sequencer #(.ERASE_SEL0_CYC(E0), .WRITE_SEL0_CYC(80),
        .ERASE_SEL1_CYC(120), .WRITE_SEL1_CYC(W1)) fiaps_sequencer_i (
        .clk_sys, .rst, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cpuHalt,
        .flashWe, .flashAddr, .flashData);
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Sampled at the falling edge, clear of the launch edge
    always @(negedge clk_sys) begin
        if (cpuHalt === 1'b1) haltCnt++;
        if (flashWe === 1'b1) begin
            weA.push_back(flashAddr);
            weD.push_back(flashData);
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(negedge clk_sys);
            ta = awvalid && awready === 1'b1;
            tw = wvalid && wready === 1'b1;
            tb = bvalid === 1'b1;
            rs = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) break;
        end
    endtask : axw
    task automatic axr(input logic [7:0] a);
        logic ta, tr;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(negedge clk_sys);
            ta = arvalid && arready === 1'b1;
            tr = rvalid === 1'b1;
            rd = rdata;
            rs = rresp;
            @(posedge clk_sys);
            if (ta) arvalid <= 1'b0;
            if (tr) break;
        end
    endtask : axr
    task automatic op(input logic [7:0] v, input int n);
        weA.delete();
        weD.delete();
        haltCnt = 0;
        axw(OFF_CTRL_MAIN, v);
        repeat (n + 40) @(posedge clk_sys);
        axr(OFF_CTRL_MAIN);
        chk(rd[POS_PROGRAM_START], 0);
        chk(haltCnt + 2 >= n && haltCnt <= n + 2, 1);
    endtask : op
    task automatic unlock(input logic [7:0] last);
        logic [7:0] ka[6] = '{OFF_KEY_A_LOW, OFF_KEY_B_LOW, OFF_KEY_C_LOW,
            OFF_KEY_A_HIGH, OFF_KEY_B_HIGH, OFF_KEY_C_HIGH};
        logic [7:0] kv[6] = '{KEY_0, KEY_1, KEY_2, KEY_3, KEY_4, last};
        axw(OFF_CTRL_MAIN, {2'h0, 1'b0, 1'b0, 1'b1, OP_UNLOCK});
        for (int i = 0; i < 6; i++) axw(ka[i], kv[i]);
        repeat (1100) @(posedge clk_sys);
    endtask : unlock
    task automatic close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        axr(8'h30);
        chk(rs, RESP_SLVERR);
        axw(8'h30, 8'h00);
        chk(rs, RESP_SLVERR);
        op(8'h10, 0);
        unlock(8'h41);
        chk(weA.size(), 0);
        axr(OFF_CTRL_MAIN);
        chk(rd[5:3], 0);
        $display("test unlock refused done");
        unlock(KEY_5);
        axr(OFF_CTRL_MAIN);
        chk(rd[5:3], 3'h4);
        axw(OFF_ADDR_HIGH, 8'h03);
        axw(OFF_ADDR_LOW, 8'h5E);
        repeat (3) axw(OFF_DATA_HIGH, 8'hFF);
        axw(OFF_CTRL_TIMING, 8'h01);
        op(8'h31, E0);
        chk(weA.size(), 2);
        chk(weA[1], 13'h035F);
        chk(weD[0], ERASED_WORD);
        $display("test erase done");
        axw(OFF_CTRL_TIMING, 8'h02);
        axw(OFF_ADDR_LOW, 8'h40);
        axw(OFF_DATA_LOW, 8'h34);
        axw(OFF_DATA_HIGH, 8'h12);
        axw(OFF_DATA_LOW, 8'h78);
        axw(OFF_DATA_HIGH, 8'h56);
        op(8'h30, W1);
        chk(weA[1], 13'h0341);
        chk({weD[0], weD[1]}, 32'h12345678);
        $display("test write done");
        axw(OFF_CTRL_TIMING, 8'h03);
        axr(OFF_CTRL_TIMING);
        chk(rd[1:0], 2'h2);
        axw(OFF_ADDR_LOW, 8'h45);
        axw(OFF_DATA_HIGH, 8'hAB);
        op(8'h30, W1);
        chk(weA.size(), 1);
        $display("test rewrite done");
        axw(OFF_CTRL_MAIN, 8'h00);
        op(8'h10, 0);
        chk(rd[POS_ERASE_WRITE_EN], 0);
        $display("test disable done");
        close_out();
    end
endmodule : fiaps_sequencer_bench

// ### dv/fiaps_sequencer_chk.sv
// Checker of bus blocking and halt timing for the sequencer
`timescale 1ns/10ps
module fiaps_sequencer_chk
    import fiaps_pkg::*;
#(
    parameter int ERASE_SEL0_CYC = 100,
    parameter int WRITE_SEL0_CYC = 80,
    parameter int ERASE_SEL1_CYC = 120,
    parameter int WRITE_SEL1_CYC = 90
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic cpuHalt,
    input wire logic flashWe
);
    // Erase is taken as the longest operation
    localparam int HMAX = 2 + (ERASE_SEL1_CYC > ERASE_SEL0_CYC ?
        ERASE_SEL1_CYC : ERASE_SEL0_CYC);
    int haltCnt_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            haltCnt_r <= 0;
        end else begin
            haltCnt_r <= cpuHalt ? haltCnt_r + 1 : 0;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////
    a_we_halted: assert property (flashWe |-> cpuHalt)
        else $error("flash write strobe outside halt");
    a_halt_min: assert property ($rose(cpuHalt) |-> cpuHalt [*8])
        else $error("halt dropped too early");
    a_halt_bound: assert property (cpuHalt |-> haltCnt_r < HMAX)
        else $error("halt lasted too long");
    a_halt_cause: assert property ($rose(cpuHalt) |-> bvalid)
        else $error("halt without a register write");
    a_halt_end: assert property ($fell(cpuHalt) |-> !flashWe)
        else $error("strobe at end of operation");
    a_write_block: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_read_block: assert property (rvalid |-> !arready)
        else $error("read taken while data pending");
    a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule : fiaps_sequencer_chk

bind fiaps_sequencer fiaps_sequencer_chk #(
    .ERASE_SEL0_CYC(ERASE_SEL0_CYC),
    .WRITE_SEL0_CYC(WRITE_SEL0_CYC),
    .ERASE_SEL1_CYC(ERASE_SEL1_CYC),
    .WRITE_SEL1_CYC(WRITE_SEL1_CYC)
) fiaps_sequencer_chk_i (.clk_sys, .rst, .awready, .wready, .bvalid,
    .arready, .rdata, .rvalid, .cpuHalt, .flashWe);
